// file: hdl/twi_target_port.sv
`timescale 1ns/10ps
// Function
// - Device is target only, never drives clock
// - 8-channel: address 01000 plus strap bits
// - Other variants: 3E,3F,70,71 by strap
// - Only 7-bit addressing is recognised
// - General call address is ignored
// - Works at 100k and 400k rates
// - Write: address, ack, index, ack
// - Data bytes stored, acked until stop
// - Write index increments or holds per setting
// - Read: index write, repeated start, read
// - Device sends bytes until master nacks
// - Read index increments or holds, same setting
// - Any register, any order, repeated start ok
// - Every register eight bits wide
// - Reset pin: full or LED counters only
// - Bus usable once reset pin high
// - Own power-on reset after fixed interval
// - Keys 12 then 34 reset all registers
module twi_target_port
  import twi_port_pkg::*;
#(
  parameter bit eight_channel         = 1'b1,
  parameter int por_completion_cycles = por_completion_cycles_def
)
(
  input  wire logic  clk,
  input  wire logic  rst,
  twi_link_if.device link,
  input  wire logic  [1:0] addr_strap,
  input  wire logic  external_reset_pin_n,
  output logic       led_counter_reset,
  output logic       por_busy
);

  // ==========================================================
  // Pin synchronisers
  logic [2:0] meta;
  logic [2:0] sync;
  logic [2:0] sync_d;
  logic [1:0] strap_meta;
  logic [1:0] strap_sync;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta       <= 3'h7;
      sync       <= 3'h7;
      sync_d     <= 3'h7;
      strap_meta <= 2'h0;
      strap_sync <= 2'h0;
    end
    else
    begin
      meta       <= {external_reset_pin_n, link.sda, link.scl};
      sync       <= meta;
      sync_d     <= sync;
      strap_meta <= addr_strap;
      strap_sync <= strap_meta;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise   = sync[0] & ~sync_d[0];
  assign scl_fall   = ~sync[0] & sync_d[0];
  assign start_cond = sync[0] & sync_d[0] & ~sync[1] & sync_d[1];
  assign stop_cond  = sync[0] & sync_d[0] & sync[1] & ~sync_d[1];

  // ==========================================================
  // Reset control
  logic [21:0] por_cnt;
  logic [21:0] next_por_cnt;
  logic [7:0]  low_cnt;
  logic [7:0]  next_low_cnt;
  logic        pin_full_reset;
  logic        pin_led_reset;
  logic        soft_reset;
  logic [7:0]  regs [reg_count];
  logic        external_reset_pin_n_full;
  assign external_reset_pin_n_full = regs[misc_config_reg[6:0]][misc_external_reset_pin_n_full_bit];
  always_comb
  begin
    next_por_cnt = por_cnt;
    if (por_cnt != 22'h00_0000)
      next_por_cnt = por_cnt - 22'h00_0001;
    next_low_cnt = 8'h00;
    if (!sync[2])
      next_low_cnt = (low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      por_cnt <= 22'(por_completion_cycles);
      low_cnt <= 8'h00;
    end
    else
    begin
      por_cnt <= next_por_cnt;
      low_cnt <= next_low_cnt;
    end
  end
  // Pulse takes effect only after the minimum low time, released with the pin
  assign pin_full_reset    = (low_cnt >= 8'(min_reset_low_cycles)) & external_reset_pin_n_full;
  assign pin_led_reset     = (low_cnt >= 8'(min_reset_low_cycles)) & ~external_reset_pin_n_full;
  assign led_counter_reset = pin_led_reset | pin_full_reset;
  assign por_busy          = (por_cnt != 22'h00_0000);

  // Soft reset clears registers only, so the key byte still gets its ack
  logic hold;
  assign hold = por_busy | pin_full_reset;

  // ==========================================================
  // Protocol engine
  typedef enum {st_idle, st_addr, st_addr_ack, st_rx, st_rx_ack, st_tx, st_tx_ack} state_t;
  state_t     state;
  state_t     next_state;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [3:0] bitn;
  logic [3:0] next_bitn;
  logic [6:0] index;
  logic [6:0] next_index;
  logic       have_index;
  logic       next_have_index;
  logic       key_armed;
  logic       next_key_armed;
  logic       sda_drive;
  logic       next_sda_drive;
  logic       next_soft_reset;
  logic       wr_en;
  logic [6:0] my_addr;
  logic       hold_index;

  always_comb
  begin
    unique case (strap_sync)
      2'b00:   my_addr = addr_alt_00;
      2'b01:   my_addr = addr_alt_01;
      2'b10:   my_addr = addr_alt_10;
      default: my_addr = addr_alt_11;
    endcase
    if (eight_channel)
      my_addr = {addr_hi_8ch, strap_sync};
  end
  assign hold_index = regs[misc_config_reg[6:0]][misc_autoinc_hold_bit];

  always_comb
  begin
    next_state      = state;
    next_shreg      = shreg;
    next_bitn       = bitn;
    next_index      = index;
    next_have_index = have_index;
    next_key_armed  = key_armed;
    next_sda_drive  = sda_drive;
    next_soft_reset = 1'b0;
    wr_en           = 1'b0;
    if (start_cond)
    begin
      next_state     = st_addr;
      next_bitn      = 4'h0;
      next_sda_drive = 1'b0;
    end
    else if (stop_cond)
    begin
      next_state     = st_idle;
      next_sda_drive = 1'b0;
    end
    else
    begin
      unique case (state)
        st_idle: ;
        st_addr, st_rx:
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sync[1]};
            next_bitn  = bitn + 4'h1;
          end
          else if (scl_fall && bitn == 4'h8)
          begin
            next_bitn = 4'h0;
            if (state == st_addr)
            begin
              // 7-bit match only; general call and 10-bit headers never match
              if (shreg[7:1] == my_addr)
              begin
                next_state      = st_addr_ack;
                next_sda_drive  = 1'b1;
                next_have_index = 1'b0;
                next_shreg      = shreg;
              end
              else
                next_state = st_idle;
            end
            else
            begin
              next_state     = st_rx_ack;
              next_sda_drive = 1'b1;
              if (!have_index)
              begin
                next_index      = shreg[6:0];
                next_have_index = 1'b1;
              end
              else
              begin
                wr_en = 1'b1;
                if (!hold_index)
                  next_index = index + 7'h01;
                if ({1'b0, index} == soft_reset_key_reg)
                begin
                  next_key_armed  = (shreg == reset_key_first);
                  next_soft_reset = key_armed && shreg == reset_key_second;
                end
              end
            end
          end
        st_addr_ack:
          if (scl_fall)
          begin
            next_sda_drive = 1'b0;
            if (shreg[0])
            begin
              next_state     = st_tx;
              next_shreg     = regs[index];
              next_sda_drive = ~regs[index][7];
              next_bitn      = 4'h1;
            end
            else
              next_state = st_rx;
          end
        st_rx_ack:
          if (scl_fall)
          begin
            next_sda_drive = 1'b0;
            next_state     = st_rx;
          end
        st_tx:
          if (scl_fall)
          begin
            if (bitn == 4'h8)
            begin
              next_sda_drive = 1'b0;
              next_state     = st_tx_ack;
              if (!hold_index)
                next_index = index + 7'h01;
            end
            else
            begin
              next_sda_drive = ~shreg[3'(7 - bitn)];
              next_bitn      = bitn + 4'h1;
            end
          end
        st_tx_ack:
          if (scl_rise && sync[1])
            next_state = st_idle;
          else if (scl_fall)
          begin
            // Host acked: next register, first bit out in this low phase
            next_state     = st_tx;
            next_shreg     = regs[index];
            next_sda_drive = ~regs[index][7];
            next_bitn      = 4'h1;
          end
        default: next_state = st_idle;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= st_idle;
      shreg      <= 8'h00;
      bitn       <= 4'h0;
      index      <= 7'h00;
      have_index <= 1'b0;
      key_armed  <= 1'b0;
      sda_drive  <= 1'b0;
      soft_reset <= 1'b0;
    end
    else if (hold)
    begin
      state      <= st_idle;
      shreg      <= 8'h00;
      bitn       <= 4'h0;
      index      <= 7'h00;
      have_index <= 1'b0;
      key_armed  <= 1'b0;
      sda_drive  <= 1'b0;
      soft_reset <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      shreg      <= next_shreg;
      bitn       <= next_bitn;
      index      <= next_index;
      have_index <= next_have_index;
      key_armed  <= next_key_armed;
      sda_drive  <= next_sda_drive;
      soft_reset <= next_soft_reset;
    end
  end

  // ==========================================================
  // Register file
  genvar g;
  generate
    for (g = 0; g < reg_count; g++)
    begin : g_reg
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          regs[g] <= reg_reset_value;
        else if (hold || soft_reset)
          regs[g] <= reg_reset_value;
        else if (wr_en && index == 7'(g))
          regs[g] <= shreg;
      end
    end
  endgenerate

  // Open drain: only ever pulls SDA low; clock is never driven
  assign link.sda_dev_o    = 1'b0;
  assign link.sda_dev_oe_n = ~sda_drive;

endmodule : twi_target_port

// file: hdl/twi_port_pkg.sv
package twi_port_pkg;

  // ==========================================================
  // Addressing
  localparam logic [4:0] addr_hi_8ch       = 5'h08;
  localparam logic [6:0] addr_alt_00       = 7'h3E;
  localparam logic [6:0] addr_alt_01       = 7'h3F;
  localparam logic [6:0] addr_alt_10       = 7'h70;
  localparam logic [6:0] addr_alt_11       = 7'h71;

  // ==========================================================
  // Register map (8-bit registers)
  localparam int         reg_count         = 128;
  localparam logic [7:0] misc_config_reg   = 8'h10;
  localparam logic [7:0] soft_reset_key_reg = 8'h7D;
  localparam int         misc_autoinc_hold_bit = 7;
  localparam logic [7:0] reset_key_first   = 8'h12;
  localparam logic [7:0] reset_key_second  = 8'h34;
  localparam int         misc_external_reset_pin_n_full_bit = 2;
  localparam logic [7:0] reg_reset_value   = 8'h00;

  // ==========================================================
  // Timing
  localparam int clk_hz                    = 25_000_000;
  localparam int min_reset_low_time_ns     = 2500;
  localparam int min_reset_low_cycles      = (min_reset_low_time_ns * 25 + 999) / 1000;
  localparam int por_completion_time_ns    = 2_500_000;
  localparam int por_completion_cycles_def = por_completion_time_ns / 40;
  localparam int std_half_ns               = 5000;
  localparam int fast_half_ns              = 1250;
  localparam int std_half_cycles           = std_half_ns / 40;
  localparam int fast_half_cycles          = fast_half_ns / 40;
  // Host bit is three ticks; rounded up so fast mode stays at or under 400 kbit/s.
  // Standard mode keeps the half-period tick to meet its longer high-time minimum.
  localparam int fast_tick_cycles          = (2 * fast_half_ns + 119) / 120;

  typedef enum logic [2:0] {op_idle, op_write, op_read} host_op_t;

endpackage : twi_port_pkg

// file: hdl/twi_link_if.sv
`timescale 1ns/10ps
interface twi_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  wire  scl = scl_oe_n ? 1'b1 : scl_o;
  wire  sda = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);

  modport device
  (
    input  scl,
    input  sda,
    output sda_dev_o,
    output sda_dev_oe_n
  );
  modport host
  (
    input  scl,
    input  sda,
    output scl_o,
    output scl_oe_n,
    output sda_host_o,
    output sda_host_oe_n
  );
endinterface : twi_link_if

// file: hdl/twi_host_master.sv
`timescale 1ns/10ps
module twi_host_master
  import twi_port_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  twi_link_if.host   link,
  input  wire logic  req,
  input  wire logic  req_read,
  input  wire logic  fast_mode,
  input  wire logic  [6:0] target_addr,
  input  wire logic  [7:0] reg_index,
  input  wire logic  [7:0] wr_data,
  output logic       busy,
  output logic       done,
  output logic       nacked,
  output logic [7:0] rd_data
);

  // ==========================================================
  // Bit-phase tick
  logic [7:0] div;
  logic       tick;
  assign tick = (div == 8'h00);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div <= 8'h00;
    else if (tick)
      div <= fast_mode ? 8'(fast_tick_cycles - 1) : 8'(std_half_cycles - 1);
    else
      div <= div - 8'h01;
  end

  logic sda_m;
  logic sda_s;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end
    else
    begin
      sda_m <= link.sda;
      sda_s <= sda_m;
    end
  end

  // ==========================================================
  // Sequencer: each bit is three ticks (scl low for two, scl high for one)
  // Program: S addr+W idx [data | Sr addr+R data NACK] P
  typedef enum {h_idle, h_start, h_byte, h_rstart, h_stop} hstate_t;
  hstate_t    st;
  hstate_t    next_st;
  logic [8:0] sh;
  logic [8:0] next_sh;
  logic [3:0] bn;
  logic [3:0] next_bn;
  logic [1:0] ph;
  logic [1:0] next_ph;
  logic [1:0] seg;
  logic [1:0] next_seg;
  logic       scl_r;
  logic       next_scl_r;
  logic       sda_r;
  logic       next_sda_r;
  logic       rd;
  logic       next_rd;
  logic       nk;
  logic       next_nk;
  logic [7:0] rdat;
  logic [7:0] next_rdat;
  logic       next_done;
  logic       done_r;

  always_comb
  begin
    next_st   = st;
    next_sh   = sh;
    next_bn   = bn;
    next_ph   = ph;
    next_seg  = seg;
    next_scl_r = scl_r;
    next_sda_r = sda_r;
    next_rd   = rd;
    next_nk   = nk;
    next_rdat = rdat;
    next_done = 1'b0;
    unique case (st)
      h_idle:
        if (req)
        begin
          next_st = h_start;
          next_rd = req_read;
          next_nk = 1'b0;
          next_ph = 2'h0;
        end
      h_start, h_rstart:
        if (tick)
        begin
          next_ph = ph + 2'h1;
          unique case (ph)
            2'h0:    begin next_sda_r = 1'b1; next_scl_r = (st == h_start); end
            2'h1:    next_scl_r = 1'b1;
            2'h2:    next_sda_r = 1'b0;
            default:
            begin
              next_scl_r = 1'b0;
              next_st    = h_byte;
              next_bn    = 4'h0;
              next_ph    = 2'h0;
              next_seg   = (st == h_start) ? 2'h0 : 2'h2;
              next_sh    = {target_addr, (st == h_rstart), 1'b1};
            end
          endcase
        end
      h_byte:
        if (tick)
        begin
          if (ph == 2'h0)
          begin
            next_sda_r = sh[8];
            next_ph    = 2'h1;
          end
          else if (ph == 2'h1)
          begin
            next_scl_r = 1'b1;
            next_ph    = 2'h2;
          end
          else
          begin
            next_scl_r = 1'b0;
            next_ph    = 2'h0;
            next_sh    = {sh[7:0], 1'b1};
            next_bn    = bn + 4'h1;
            if (seg == 2'h3 && bn < 4'h8)
              next_rdat = {rdat[6:0], sda_s};
            if (bn == 4'h8)
            begin
              if (sda_s && seg != 2'h3)
              begin
                next_nk = 1'b1;
                next_st = h_stop;
              end
              else
              begin
                next_bn  = 4'h0;
                next_seg = seg + 2'h1;
                unique case (seg)
                  2'h0: next_sh = {reg_index, 1'b1};
                  2'h1:
                    if (rd)
                      next_st = h_rstart;
                    else
                      next_sh = {wr_data, 1'b1};
                  2'h2: next_sh = 9'h1FF; // Release for read, NACK last
                  default: next_st = h_stop;
                endcase
                if (seg == 2'h2 && !rd)
                  next_st = h_stop;
              end
            end
          end
        end
      h_stop:
        if (tick)
        begin
          next_ph = ph + 2'h1;
          unique case (ph)
            2'h0:    next_sda_r = 1'b0;
            2'h1:    next_scl_r = 1'b1;
            2'h2:    next_sda_r = 1'b1;
            default:
            begin
              next_st   = h_idle;
              next_done = 1'b1;
            end
          endcase
        end
      default: next_st = h_idle;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st     <= h_idle;
      sh     <= 9'h1FF;
      bn     <= 4'h0;
      ph     <= 2'h0;
      seg    <= 2'h0;
      scl_r  <= 1'b1;
      sda_r  <= 1'b1;
      rd     <= 1'b0;
      nk     <= 1'b0;
      rdat   <= 8'h00;
      done_r <= 1'b0;
    end
    else
    begin
      st     <= next_st;
      sh     <= next_sh;
      bn     <= next_bn;
      ph     <= next_ph;
      seg    <= next_seg;
      scl_r  <= next_scl_r;
      sda_r  <= next_sda_r;
      rd     <= next_rd;
      nk     <= next_nk;
      rdat   <= next_rdat;
      done_r <= next_done;
    end
  end

  assign link.scl_o         = 1'b0;
  assign link.scl_oe_n      = scl_r;
  assign link.sda_host_o    = 1'b0;
  assign link.sda_host_oe_n = sda_r;
  assign busy    = (st != h_idle);
  assign done    = done_r;
  assign nacked  = nk;
  assign rd_data = rdat;

endmodule : twi_host_master

// file: testbench/twi_link_checker.sv
`timescale 1ns/10ps
module twi_link_checker
  import twi_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe_n
);
  // ==========================================================
  // Frame decoding from the wire levels
  logic       p_scl, p_sda, rd, quiet, next_rd, next_quiet;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [1:0] byte_no, next_byte_no;
  logic [7:0] shreg, next_shreg;
  wire        rise  = scl & ~p_scl;
  wire        start = scl & p_scl & p_sda & ~sda;
  wire        ack   = rise & (bit_cnt == 4'h8);

  always_comb
  begin
    next_bit_cnt = bit_cnt;
    next_byte_no = byte_no;
    next_shreg   = shreg;
    next_rd      = rd;
    next_quiet   = quiet;
    if (start)
    begin
      next_bit_cnt = 4'h0;
      next_byte_no = 2'h0;
      next_quiet   = 1'b0;
    end
    else if (ack)
    begin
      next_bit_cnt = 4'h0;
      next_byte_no = (byte_no == 2'h3) ? byte_no : byte_no + 2'h1;
      if (byte_no == 2'h0)
      begin
        next_rd    = shreg[0];
        next_quiet = sda;
      end
    end
    else if (rise)
    begin
      next_bit_cnt = bit_cnt + 4'h1;
      next_shreg   = {shreg[6:0], sda};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      p_scl   <= 1'b1;
      p_sda   <= 1'b1;
      bit_cnt <= 4'h0;
      byte_no <= 2'h0;
      shreg   <= 8'h00;
      rd      <= 1'b0;
      quiet   <= 1'b0;
    end
    else
    begin
      p_scl   <= scl;
      p_sda   <= sda;
      bit_cnt <= next_bit_cnt;
      byte_no <= next_byte_no;
      shreg   <= next_shreg;
      rd      <= next_rd;
      quiet   <= next_quiet;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_pull_clk_low;
    $fell(sda_dev_oe_n) |-> !scl;
  endproperty
  property p_free_clk_low;
    $rose(sda_dev_oe_n) |-> !scl;
  endproperty
  property p_gcall_nack;
    ack && byte_no == 2'h0 && shreg == 8'h00 |-> sda;
  endproperty
  property p_own_addr;
    ack && byte_no == 2'h0 && !sda |-> shreg[7:3] == addr_hi_8ch;
  endproperty
  property p_quiet;
    quiet |-> sda_dev_oe_n;
  endproperty
  property p_index_ack;
    ack && byte_no == 2'h1 && !rd && !quiet |-> !sda;
  endproperty
  property p_data_ack;
    ack && byte_no >= 2'h2 && !rd && !quiet |-> !sda;
  endproperty
  property p_read_release;
    ack && byte_no != 2'h0 && rd |-> sda_dev_oe_n [*3];
  endproperty

  a_pull_clk_low: assert property (p_pull_clk_low)
    else $error("device pulled data while clock high");
  a_free_clk_low: assert property (p_free_clk_low)
    else $error("device released data while clock high");
  a_gcall_nack: assert property (p_gcall_nack)
    else $error("general call acknowledged");
  a_own_addr: assert property (p_own_addr)
    else $error("address outside own range acknowledged");
  a_quiet: assert property (p_quiet)
    else $error("device drove data after refusing the address");
  a_index_ack: assert property (p_index_ack)
    else $error("index byte not acknowledged");
  a_data_ack: assert property (p_data_ack)
    else $error("data byte not acknowledged");
  a_read_release: assert property (p_read_release)
    else $error("device held data during host acknowledge slot");

  c_index_ack: cover property (ack && byte_no == 2'h1 && !sda);
  c_read_data: cover property (ack && rd && byte_no == 2'h1);
  c_foreign: cover property (ack && byte_no == 2'h0 && sda);
endmodule : twi_link_checker

// file: testbench/test_i2c_slave_register_port.sv
`timescale 1ns/10ps
module test_i2c_slave_register_port
  import twi_port_pkg::*;
;
  logic       clk, rst, req, req_read, fast_mode, pin_n, fm;
  logic       busy_a, nacked_a, led_a, por_a, busy_b, nacked_b, led_b, done_a, got_done;
  logic [1:0] strap;
  logic [6:0] target_addr;
  logic [7:0] reg_index, wr_data, rd_a, idx, val;
  logic [7:0] mem [128];
  logic [6:0] alt [4];
  integer     num_errors, comparisons, cycles, seed, n;

  twi_link_if link_a ();
  twi_link_if link_b ();

  twi_target_port #(.eight_channel(1'b1), .por_completion_cycles(20)) twi_target_port_inst (
    .clk(clk), .rst(rst), .link(link_a), .addr_strap(strap), .external_reset_pin_n(pin_n),
    .led_counter_reset(led_a), .por_busy(por_a));
  twi_target_port #(.eight_channel(1'b0), .por_completion_cycles(20)) alt_twi_target_port_inst (
    .clk(clk), .rst(rst), .link(link_b), .addr_strap(strap), .external_reset_pin_n(pin_n),
    .led_counter_reset(led_b), .por_busy());
  twi_host_master twi_host_master_inst (
    .clk(clk), .rst(rst), .link(link_a), .req(req), .req_read(req_read), .fast_mode(fast_mode),
    .target_addr(target_addr), .reg_index(reg_index), .wr_data(wr_data), .busy(busy_a),
    .done(done_a), .nacked(nacked_a), .rd_data(rd_a));
  twi_host_master alt_twi_host_master_inst (
    .clk(clk), .rst(rst), .link(link_b), .req(req), .req_read(req_read), .fast_mode(fast_mode),
    .target_addr(target_addr), .reg_index(reg_index), .wr_data(wr_data), .busy(busy_b),
    .done(), .nacked(nacked_b), .rd_data());
  twi_link_checker twi_link_checker_inst (
    .clk(clk), .rst(rst), .scl(link_a.scl), .sda(link_a.sda), .sda_dev_oe_n(link_a.sda_dev_oe_n));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // Checking and transfer tasks
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Both hosts get the same request; finished when both are idle
  task automatic xfer(input logic r, input logic f, input logic [6:0] a, input logic [7:0] i,
                      input logic [7:0] d);
    @(negedge clk);
    req_read    = r;
    fast_mode   = f;
    target_addr = a;
    reg_index   = i;
    wr_data     = d;
    req         = 1'b1;
    @(negedge clk);
    req = 1'b0;
    @(negedge clk);
    got_done = 1'b0;
    while (busy_a !== 1'b0 || busy_b !== 1'b0)
    begin
      @(negedge clk);
      got_done = got_done | done_a;
    end
    check({7'h00, got_done}, 8'h01);
  endtask : xfer

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b0, fm, {addr_hi_8ch, strap}, i, d);
    check({7'h00, nacked_a}, 8'h00);
    mem[i[6:0]] = d;
  endtask : wr

  task automatic rd_chk(input logic [7:0] i);
    xfer(1'b1, fm, {addr_hi_8ch, strap}, i, 8'h00);
    check(rd_a, mem[i[6:0]]);
  endtask : rd_chk

  task automatic pin_pulse(input logic [7:0] cfg);
    wr(8'h30, 8'hC3);
    wr(misc_config_reg, cfg);
    @(negedge clk);
    pin_n = 1'b0;
    repeat (min_reset_low_cycles + 4) @(negedge clk);
    check({6'h00, led_b, led_a}, 8'h03);
    pin_n = 1'b1;
    if (cfg != 8'h00)
      foreach (mem[k]) mem[k] = reg_reset_value;
    rd_chk(8'h30);
    rd_chk(misc_config_reg);
    check({6'h00, led_b, led_a}, 8'h00);
  endtask : pin_pulse

  // Hang guard, roughly 12 percent above the expected run length of about 94000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 105000)
    begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    req = 1'b0;
    req_read = 1'b0;
    fast_mode = 1'b1;
    fm = 1'b1;
    target_addr = 7'h00;
    reg_index = 8'h00;
    wr_data = 8'h00;
    pin_n = 1'b1;
    strap = 2'h0;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    seed = 32;
    alt = '{addr_alt_00, addr_alt_01, addr_alt_10, addr_alt_11};
    foreach (mem[k]) mem[k] = reg_reset_value;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    check({7'h00, por_a}, 8'h01);
    repeat (20) @(negedge clk);
    check({7'h00, por_a}, 8'h00);
    for (n = 0; n < 4; n++)
    begin
      strap = n[1:0];
      xfer(1'b0, 1'b1, {addr_hi_8ch, strap}, 8'h20, 8'(n));
      check({6'h00, nacked_b, nacked_a}, 8'h02);
      xfer(1'b0, 1'b1, alt[n], 8'h20, 8'h00);
      check({6'h00, nacked_b, nacked_a}, 8'h01);
      xfer(1'b0, 1'b1, {addr_hi_8ch, ~strap}, 8'h20, 8'h00);
      check({6'h00, nacked_b, nacked_a}, 8'h03);
    end
    mem[32] = 8'h03;
    for (n = 0; n < 2; n++)
    begin
      xfer(1'b0, 1'b1, (n == 0) ? 7'h00 : 7'h7A, 8'h20, 8'h55);
      check({6'h00, nacked_b, nacked_a}, 8'h03);
    end
    rd_chk(8'h20);
    for (n = 0; n < 3; n++)
    begin
      fm = (n != 0);
      idx = 8'($random(seed)) & 8'h3F;
      val = 8'($random(seed));
      if (idx == misc_config_reg)
        idx = 8'h11;
      wr(idx, val);
      rd_chk(idx);
    end
    wr(8'h30, 8'h5A);
    wr(soft_reset_key_reg, reset_key_first);
    wr(soft_reset_key_reg, 8'h55);
    wr(soft_reset_key_reg, reset_key_second);
    rd_chk(8'h30);
    wr(soft_reset_key_reg, reset_key_first);
    wr(soft_reset_key_reg, reset_key_second);
    foreach (mem[k]) mem[k] = reg_reset_value;
    rd_chk(8'h30);
    rd_chk(idx);
    pin_pulse(8'h00);
    pin_pulse(8'h04);
    complete_run();
  end
endmodule : test_i2c_slave_register_port
